// ===== hdl/rst_opt_cfg.svh
// Constants for the reset, settle and option block
`ifndef RST_OPT_CFG_SVH
`define RST_OPT_CFG_SVH

// Timing
`define CLK_MHZ          125
`define LOW_HOLD_US      1000
`define LOW_HOLD_CLKS    (`LOW_HOLD_US * `CLK_MHZ)
`define SETTLE_CLKS      1024
`define WDT_BASE_EXP     12

// Register byte offsets
`define ADDR_OPTION      8'h00
`define ADDR_PORTOPT     8'h04
`define ADDR_STATUS      8'h08
`define ADDR_WDTCNT      8'h0C

// OPTION fields
`define OPT_LOW_EN       0
`define OPT_WSRC_LO      1
`define OPT_DBLCLR       3
`define OPT_TSEL_LO      4
`define OPT_PFD          6
`define OPT_PWM62        7
`define OPT_PWMPIN       8
`define OPT_XTAL         9
`define OPTION_MASK      32'h0000_03FF
`define OPTION_RST       32'h0000_0001

// PORTOPT fields
`define POPT_WAKE_LO     0
`define POPT_PULLA_LO    8
`define POPT_PULLB       16
`define POPT_PULLC       17
`define POPT_PULLD       18
`define PORTOPT_MASK     32'h0007_FFFF
`define PORTOPT_RST      32'h0000_0000

// STATUS fields
`define ST_CHIP_RST      0
`define ST_RUN           1
`define ST_LOW_REQ       2
`define ST_EXT_REQ       3
`define ST_CLR_FIRST     4
`define ST_CLR_SECOND    5

// Watchdog source codes
`define WSRC_RC          2'h0
`define WSRC_INSTR       2'h1

// AXI responses
`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2

`endif

// ===== hdl/rst_opt_pkg.sv
// Types for the reset, settle and option block
`include "rst_opt_cfg.svh"

package rst_opt_pkg;

    typedef enum logic [1:0] {PH_HOLD, PH_SETTLE, PH_RUN} phase_t;

    typedef struct packed {
        logic [1:0]  low_sync;
        logic [1:0]  clr_sync;
        logic [1:0]  rc_sync;
        logic        rc_prev;
        logic [7:0]  pa_s1;
        logic [7:0]  pa_s2;
        logic [7:0]  pa_prev;
        logic [31:0] low_cnt;
        logic        low_req;
        logic        ext_req;
        logic        chip_reset;
        phase_t      phase;
        logic [15:0] settle_cnt;
        logic [14:0] wdt_cnt;
        logic        clr_first;
        logic        clr_second;
        logic        wdt_timeout;
        logic        wake;
        logic        pa3_out;
        logic        pd0_out;
        logic [31:0] option;
        logic [31:0] portopt;
        logic        aw_got;
        logic [7:0]  aw_addr;
        logic        w_got;
        logic [31:0] w_data;
        logic [3:0]  w_strb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } state_t;

endpackage

// ===== hdl/low_voltage_reset_and_options.sv
// Chip reset combiner, low-supply filter, settle timer, watchdog and option registers
//
// Notes on behaviour
// - Option bit enables or disables low-supply reset.
// - Low supply resets only after exceeding 1 ms.
// - Chip reset is low-supply OR reset pin.
// - Count 1024 clocks after release before running.
// - Watchdog clock: RC, instruction clock, or off.
// - Single mode: one clear resets watchdog.
// - Double mode: both clears needed before reset.
// - Port A falling edge wakes from halt.
// - Pull-high per bit A, per port B-D.
// - Port A bit3 selects level or divider output.
// - PWM mode option; port D bit0 level/PWM.
// - Watchdog timeout at source over 2^12..2^15.
// - Option selects RC or crystal system clock.
//
// Chosen here: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`include "rst_opt_cfg.svh"

module low_voltage_reset_and_options #(
    parameter int ADDR_W          = 8,
    parameter int LOW_HOLD_CYCLES = `LOW_HOLD_CLKS,
    parameter int SETTLE_CYCLES   = `SETTLE_CLKS
) (
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              sys_rst,
    // AXI4-Lite slave
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    // Reset sources (asynchronous pins)
    input  wire logic              supply_low,
    input  wire logic              external_chip_clear_input_n,
    // Watchdog sources and clear strobes (core clock domain except rc_osc)
    input  wire logic              rc_osc,
    input  wire logic              instr_tick,
    input  wire logic              watchdog_clear_single,
    input  wire logic              watchdog_clear_first,
    input  wire logic              watchdog_clear_second,
    // Wake-up
    input  wire logic              halted,
    input  wire logic [7:0]        port_a_in,
    // Pin function sources
    input  wire logic              port_a_bit3_level,
    input  wire logic              frequency_divider_output,
    input  wire logic              port_d_bit0_level,
    input  wire logic              pwm_in,
    // Results
    output logic                   chip_reset,
    output logic                   normal_run,
    output logic                   low_supply_detector,
    output logic [14:0]            watchdog_counter,
    output logic                   watchdog_timeout,
    output logic                   wake,
    output logic [7:0]             port_a_pull,
    output logic                   port_b_pull,
    output logic                   port_c_pull,
    output logic                   port_d_pull,
    output logic                   port_a_bit3,
    output logic                   port_d_bit0,
    output logic                   pwm_mode_6p2,
    output logic                   osc_crystal
);

    rst_opt_pkg::state_t s;
    rst_opt_pkg::state_t next_s;

    // Register map, one aligned word each:
    //   OPTION  b0 low-supply reset enable
    //           b2:1 watchdog source: 0 RC, 1 instr, else off
    //           b3 double clear, b5:4 timeout select
    //           b6 bit3 divider, b7 PWM 6+2, b8 bit0 PWM
    //           b9 crystal oscillator
    //   PORTOPT b7:0 wake enables, b15:8 port A pulls
    //           b16..b18 whole-port pulls for B, C, D
    //   STATUS  read-only view of the reset chain
    //   WDTCNT  read-only watchdog count
    // Options live in flops instead of fuses, so software
    // may change them at run time; only sys_rst restores
    // them, never the chip reset that they control.

    // Byte-lane merge; bits outside the mask read zero

    function automatic logic [31:0] merge_strb(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0]  strb,
                                               input logic [31:0] mask);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r & mask;
    endfunction

    // Last count value before a watchdog wrap, for selections 0..3
    function automatic logic [14:0] wdt_limit(input logic [1:0] sel);
        logic [15:0] one_hot;
        one_hot = 16'h0001 << (`WDT_BASE_EXP + int'(sel));
        return 15'(one_hot - 16'h0001);
    endfunction

    // True once the settle count has finished
    function automatic logic in_run(input rst_opt_pkg::phase_t ph);
        return ph == rst_opt_pkg::PH_RUN;
    endfunction

    logic [1:0]  wsrc;
    logic        wdt_tick;
    logic        clr_now;
    logic        first_seen;
    logic        second_seen;
    logic [7:0]  pa_fall;
    logic [31:0] rd_val;
    logic        rd_ok;
    logic        wr_ok;

    assign s_axi_awready = !s.aw_got && !s.bvalid;
    assign s_axi_wready  = !s.w_got && !s.bvalid;
    assign s_axi_arready = !s.rvalid;
    assign s_axi_bvalid  = s.bvalid;
    assign s_axi_bresp   = s.bresp;
    assign s_axi_rvalid  = s.rvalid;
    assign s_axi_rdata   = s.rdata;
    assign s_axi_rresp   = s.rresp;

    assign chip_reset          = s.chip_reset;
    assign normal_run          = in_run(s.phase);
    assign low_supply_detector = s.low_req;
    assign watchdog_counter    = s.wdt_cnt;
    assign watchdog_timeout    = s.wdt_timeout;
    assign wake                = s.wake;
    assign port_a_pull         = s.portopt[`POPT_PULLA_LO +: 8];
    assign port_b_pull         = s.portopt[`POPT_PULLB];
    assign port_c_pull         = s.portopt[`POPT_PULLC];
    assign port_d_pull         = s.portopt[`POPT_PULLD];
    assign port_a_bit3         = s.pa3_out;
    assign port_d_bit0         = s.pd0_out;
    assign pwm_mode_6p2        = s.option[`OPT_PWM62];
    assign osc_crystal         = s.option[`OPT_XTAL];

    always_comb begin
        next_s = s;
        wsrc = s.option[`OPT_WSRC_LO +: 2];
        rd_val = 32'h0000_0000;
        rd_ok = 1'b1;
        wr_ok = 1'b1;

        // Pins and the RC clock are free-running, so each one
        // passes two flops before logic reads it; port A keeps
        // a third copy for the edge detector.
        // Synchronisers: the second stage is looked at, and port A's third as well
        next_s.low_sync = {s.low_sync[0], supply_low};
        next_s.clr_sync = {s.clr_sync[0], external_chip_clear_input_n};
        next_s.rc_sync  = {s.rc_sync[0], rc_osc};
        next_s.rc_prev  = s.rc_sync[1];
        next_s.pa_s1    = port_a_in;
        next_s.pa_s2    = s.pa_s1;
        next_s.pa_prev  = s.pa_s2;

        // Low-supply persistence filter; a short dip clears the count
        // The count must reach LOW_HOLD_CYCLES with the supply
        // still low, so a dip needs LOW_HOLD_CYCLES+1 samples.
        if (!s.option[`OPT_LOW_EN] || !s.low_sync[1]) begin
            next_s.low_cnt = 32'h0000_0000;
            next_s.low_req = 1'b0;
        end else if (s.low_cnt >= 32'(LOW_HOLD_CYCLES)) begin
            next_s.low_req = 1'b1;
        end else begin
            next_s.low_cnt = s.low_cnt + 32'h0000_0001;
        end

        next_s.ext_req    = !s.clr_sync[1];
        next_s.chip_reset = s.low_req || s.ext_req;

        // With a quiet supply chip_reset falls four edges after
        // sys_rst: two sync flops, the request flop, then the
        // reset flop. Run needs one HOLD cycle and then
        // SETTLE_CYCLES cycles in SETTLE.
        // Settle timer, restarted by any reset reassertion
        if (s.chip_reset) begin
            next_s.phase = rst_opt_pkg::PH_HOLD;
            next_s.settle_cnt = 16'h0000;
        end else begin
            case (s.phase)
                rst_opt_pkg::PH_HOLD: begin
                    next_s.phase = rst_opt_pkg::PH_SETTLE;
                    next_s.settle_cnt = 16'h0000;
                end
                rst_opt_pkg::PH_SETTLE: begin
                    next_s.settle_cnt = s.settle_cnt + 16'h0001;
                    if (s.settle_cnt == 16'(SETTLE_CYCLES - 1)) begin
                        next_s.phase = rst_opt_pkg::PH_RUN;
                    end
                end
                rst_opt_pkg::PH_RUN: begin
                    next_s.phase = rst_opt_pkg::PH_RUN;
                end
                default: begin
                    next_s.phase = rst_opt_pkg::PH_HOLD;
                end
            endcase
        end

        // Double clear keeps each strobe until its partner comes;
        // both in one cycle clear at once. A wrap only pulses
        // watchdog_timeout; what acts on it lives outside.
        // Watchdog source; any other code stops the counter
        case (wsrc)
            `WSRC_RC:    wdt_tick = s.rc_sync[1] && !s.rc_prev;
            `WSRC_INSTR: wdt_tick = instr_tick;
            default:     wdt_tick = 1'b0;
        endcase

        first_seen  = s.clr_first || watchdog_clear_first;
        second_seen = s.clr_second || watchdog_clear_second;
        if (s.option[`OPT_DBLCLR]) begin
            clr_now = first_seen && second_seen;
            next_s.clr_first  = first_seen && !clr_now;
            next_s.clr_second = second_seen && !clr_now;
        end else begin
            clr_now = watchdog_clear_single;
            next_s.clr_first  = 1'b0;
            next_s.clr_second = 1'b0;
        end

        next_s.wdt_timeout = 1'b0;
        if (s.chip_reset || clr_now) begin
            next_s.wdt_cnt = 15'h0000;
        end else if (wdt_tick) begin
            if (s.wdt_cnt >= wdt_limit(s.option[`OPT_TSEL_LO +: 2])) begin
                next_s.wdt_cnt = 15'h0000;
                next_s.wdt_timeout = 1'b1;
            end else begin
                next_s.wdt_cnt = s.wdt_cnt + 15'h0001;
            end
        end

        // Wake-up on an enabled falling edge, port A only
        // pa_prev resets low, so no false edge follows reset
        pa_fall = s.pa_prev & ~s.pa_s2 & s.portopt[`POPT_WAKE_LO +: 8];
        next_s.wake = halted && (|pa_fall);

        // Pin muxes are registered so a pin never glitches
        // while an option bit changes
        next_s.pa3_out = s.option[`OPT_PFD] ? frequency_divider_output : port_a_bit3_level;
        next_s.pd0_out = s.option[`OPT_PWMPIN] ? pwm_in : port_d_bit0_level;

        // Each write half is held once taken and its ready drops,
        // so address and data may come in either order.
        // AXI write: address and data in either order, answer once both held
        if (s_axi_awvalid && s_axi_awready) begin
            next_s.aw_got = 1'b1;
            next_s.aw_addr = 8'(s_axi_awaddr);
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_s.w_got = 1'b1;
            next_s.w_data = s_axi_wdata;
            next_s.w_strb = s_axi_wstrb;
        end
        if (s.aw_got && s.w_got) begin
            case (s.aw_addr)
                `ADDR_OPTION:  next_s.option = merge_strb(s.option, s.w_data, s.w_strb, `OPTION_MASK);
                `ADDR_PORTOPT: next_s.portopt = merge_strb(s.portopt, s.w_data, s.w_strb, `PORTOPT_MASK);
                `ADDR_STATUS:  wr_ok = 1'b1;
                `ADDR_WDTCNT:  wr_ok = 1'b1;
                default:       wr_ok = 1'b0;
            endcase
            next_s.aw_got = 1'b0;
            next_s.w_got = 1'b0;
            next_s.bvalid = 1'b1;
            next_s.bresp = wr_ok ? `RESP_OKAY : `RESP_SLVERR;
        end else if (s.bvalid && s_axi_bready) begin
            next_s.bvalid = 1'b0;
        end

        // AXI read
        // arready falls while rvalid stands, so the answer is
        // never overwritten; unmapped reads give zero, SLVERR.
        case (8'(s_axi_araddr))
            `ADDR_OPTION:  rd_val = s.option;
            `ADDR_PORTOPT: rd_val = s.portopt;
            `ADDR_STATUS: begin
                rd_val[`ST_CHIP_RST]   = s.chip_reset;
                rd_val[`ST_RUN]        = in_run(s.phase);
                rd_val[`ST_LOW_REQ]    = s.low_req;
                rd_val[`ST_EXT_REQ]    = s.ext_req;
                rd_val[`ST_CLR_FIRST]  = s.clr_first;
                rd_val[`ST_CLR_SECOND] = s.clr_second;
            end
            `ADDR_WDTCNT:  rd_val = {17'h00000, s.wdt_cnt};
            default:       rd_ok = 1'b0;
        endcase
        if (s_axi_arvalid && s_axi_arready) begin
            next_s.rvalid = 1'b1;
            next_s.rdata = rd_val;
            next_s.rresp = rd_ok ? `RESP_OKAY : `RESP_SLVERR;
        end else if (s.rvalid && s_axi_rready) begin
            next_s.rvalid = 1'b0;
        end
    end

    // Chip reset starts asserted so the core stays held until the pins are seen
    // and the settle count always runs in full after power-up
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s <= '0;
            s.chip_reset <= 1'b1;
            s.ext_req <= 1'b1;
            s.option <= `OPTION_RST;
            s.portopt <= `PORTOPT_RST;
        end else begin
            s <= next_s;
        end
    end

endmodule

// ===== testbench/low_voltage_reset_and_options_assertions.sv
// Checker for the reset, settle and option block
`timescale 1ns/1ps
module low_voltage_reset_and_options_checker #(
    parameter int LOW_HOLD_CYCLES = 20,
    parameter int SETTLE_CYCLES   = 16
) (
    // Clock and reset
    input wire logic        clk,
    input wire logic        sys_rst,
    // Sources
    input wire logic        supply_low,
    input wire logic        external_chip_clear_input_n,
    input wire logic        halted,
    input wire logic        port_a_bit3_level,
    input wire logic        frequency_divider_output,
    // Results
    input wire logic        chip_reset,
    input wire logic        normal_run,
    input wire logic        low_supply_detector,
    input wire logic [14:0] watchdog_counter,
    input wire logic        wake,
    input wire logic        port_a_bit3
);
    logic [15:0] free_cnt;
    // Saturates so a long run never wraps back into the settle window
    always_ff @(posedge clk) begin
        if (sys_rst || chip_reset) begin
            free_cnt <= 16'h0000;
        end else if (free_cnt != 16'hFFFF) begin
            free_cnt <= free_cnt + 16'h0001;
        end
    end
    default clocking @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    AST_LOW_TO_CHIP: assert property (low_supply_detector |=> chip_reset)
        else $error("low supply did not reset chip");
    AST_PIN_TO_CHIP: assert property (!external_chip_clear_input_n [*5] |-> chip_reset)
        else $error("pin did not reset chip");
    AST_LOW_GONE: assert property (!supply_low [*5] |-> !low_supply_detector)
        else $error("low request outlived supply");
    AST_RUN_LATE: assert property (free_cnt == SETTLE_CYCLES + 3 |-> normal_run)
        else $error("run too late");
    AST_RUN_EARLY: assert property (normal_run |-> free_cnt >= SETTLE_CYCLES)
        else $error("run too early");
    AST_RST_STOPS: assert property (chip_reset |=> !normal_run)
        else $error("run during reset");
    AST_WDT_STEP: assert property (watchdog_counter != $past(watchdog_counter)
        |-> watchdog_counter == 15'h0000 || watchdog_counter == $past(watchdog_counter) + 15'h0001)
        else $error("watchdog jumped");
    AST_WDT_HELD: assert property (chip_reset |=> watchdog_counter == 15'h0000)
        else $error("watchdog ran in reset");
    AST_NO_WAKE: assert property (!halted [*6] |-> !wake)
        else $error("wake while running");
    AST_PA3_SRC: assert property ($past(port_a_bit3_level) == $past(frequency_divider_output)
        |-> port_a_bit3 == $past(port_a_bit3_level))
        else $error("bit3 from no source");
endmodule
bind low_voltage_reset_and_options low_voltage_reset_and_options_checker #(
    .LOW_HOLD_CYCLES(LOW_HOLD_CYCLES),
    .SETTLE_CYCLES(SETTLE_CYCLES)
) checker_inst (.*);

// ===== testbench/supply_pin_model.sv
// Supply monitor and reset pin model
`timescale 1ns/1ps
module supply_pin_model (
    // Clock
    input  wire logic clk,
    // Pins
    output logic      supply_low,
    output logic      external_chip_clear_input_n
);
    // Pin has a pull-up, so released means high
    initial begin
        supply_low = 1'h0;
        external_chip_clear_input_n = 1'h1;
    end
    task automatic dip(input int n);
        supply_low <= 1'h1;
        repeat (n) @(posedge clk);
        supply_low <= 1'h0;
    endtask
    task automatic press(input int n);
        external_chip_clear_input_n <= 1'h0;
        repeat (n) @(posedge clk);
        external_chip_clear_input_n <= 1'h1;
    endtask
endmodule

// ===== testbench/test_low_voltage_reset_and_options.sv
// Testbench for the reset, settle and option block
`timescale 1ns/1ps
`include "rst_opt_cfg.svh"
module test_low_voltage_reset_and_options;
    localparam int LH = 20;
    localparam int ST = 16;
    logic clk = 1'h0, sys_rst = 1'h1, halted = 1'h0, rc_osc = 1'h0, instr_tick = 1'h0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, port_a_in = 8'hFF, port_a_pull;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
    logic s_axi_rready = 1'h0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic watchdog_clear_single = 1'h0, watchdog_clear_first = 1'h0, watchdog_clear_second = 1'h0;
    logic port_a_bit3_level = 1'h0, frequency_divider_output = 1'h1, port_d_bit0_level = 1'h0, pwm_in = 1'h1;
    logic supply_low, external_chip_clear_input_n, chip_reset, normal_run, low_supply_detector;
    logic watchdog_timeout, wake, port_b_pull, port_c_pull, port_d_pull, port_a_bit3, port_d_bit0;
    logic pwm_mode_6p2, osc_crystal;
    logic [14:0] watchdog_counter;
    int err_count = 0, compares = 0, n_rst = 0, n_to = 0, n_wk = 0, n0, t;
    always #4 clk = ~clk;
    always @(posedge clk) begin
        if (chip_reset === 1'h1) n_rst++;
        if (watchdog_timeout === 1'h1) n_to++;
        if (wake === 1'h1) n_wk++;
    end
    supply_pin_model supply_pin_model_inst (.clk(clk), .supply_low(supply_low),
        .external_chip_clear_input_n(external_chip_clear_input_n));
    low_voltage_reset_and_options #(.LOW_HOLD_CYCLES(LH), .SETTLE_CYCLES(ST)) low_voltage_reset_and_options_inst (.*);
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic report_and_stop();
        $display("errors %0d compares %0d", err_count, compares);
        if (err_count == 0 && compares > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic hung();
        err_count++;
        $display("[ERR] %0t timeout", $time);
        report_and_stop();
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic aw, w, bv;
        logic [1:0] br;
        int n;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        for (n = 0; n < 50; n++) begin
            #1;
            aw = s_axi_awready;
            w = s_axi_wready;
            bv = s_axi_bvalid;
            br = s_axi_bresp;
            @(posedge clk);
            if (aw) s_axi_awvalid <= 1'h0;
            if (w) s_axi_wvalid <= 1'h0;
            if (bv) break;
        end
        s_axi_bready <= 1'h0;
        if (n == 50) hung();
        chk(32'(br), 32'(er));
        @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        logic ar, rv;
        logic [31:0] d;
        logic [1:0] r;
        int n;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        for (n = 0; n < 50; n++) begin
            #1;
            ar = s_axi_arready;
            rv = s_axi_rvalid;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge clk);
            if (ar) s_axi_arvalid <= 1'h0;
            if (rv) break;
        end
        s_axi_rready <= 1'h0;
        if (n == 50) hung();
        chk(d, ed);
        chk(32'(r), 32'(er));
        @(posedge clk);
    endtask
    // Counts edges from chip reset falling to normal run rising
    task automatic wait_run();
        int n, k;
        for (n = 0; n < 500; n++) begin
            #1;
            if (chip_reset === 1'h1) break;
            @(posedge clk);
        end
        if (n == 500) hung();
        for (n = 0; n < 500; n++) begin
            #1;
            if (chip_reset === 1'h0) break;
            @(posedge clk);
        end
        for (k = 0; k < 500 && n < 500; k++) begin
            @(posedge clk);
            #1;
            if (normal_run === 1'h1) break;
        end
        if (n == 500 || k == 500) hung();
        chk(k + 1, ST + 1);
        @(posedge clk);
    endtask
    task automatic tick(input int k);
        instr_tick <= 1'h1;
        repeat (k) @(posedge clk);
        instr_tick <= 1'h0;
        repeat (2) @(posedge clk);
    endtask
    task automatic settle(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    initial begin
        repeat (6) @(posedge clk);
        sys_rst <= 1'h0;
        wait_run();
        rd(`ADDR_OPTION, `OPTION_RST, `RESP_OKAY);
        rd(`ADDR_PORTOPT, `PORTOPT_RST, `RESP_OKAY);
        rd(8'h10, 32'h0, `RESP_SLVERR);
        wr(8'h10, 32'hFFFF_FFFF, `RESP_SLVERR);
        n0 = n_rst;
        supply_pin_model_inst.dip(LH);
        settle(8);
        chk(n_rst - n0, 0);
        supply_pin_model_inst.dip(LH + 2);
        wait_run();
        wr(`ADDR_OPTION, 32'h0, `RESP_OKAY);
        n0 = n_rst;
        supply_pin_model_inst.dip(LH + 5);
        settle(8);
        chk(n_rst - n0, 0);
        wr(`ADDR_OPTION, 32'h3, `RESP_OKAY);
        supply_pin_model_inst.press(8);
        wait_run();
        supply_pin_model_inst.press(8);
        repeat (12) @(posedge clk);
        supply_pin_model_inst.press(8);
        wait_run();
        tick(5);
        rd(`ADDR_WDTCNT, 32'h5, `RESP_OKAY);
        chk(32'(watchdog_counter), 32'h5);
        watchdog_clear_single <= 1'h1;
        @(posedge clk);
        watchdog_clear_single <= 1'h0;
        settle(2);
        rd(`ADDR_WDTCNT, 32'h0, `RESP_OKAY);
        wr(`ADDR_OPTION, 32'hB, `RESP_OKAY);
        tick(3);
        watchdog_clear_first <= 1'h1;
        @(posedge clk);
        watchdog_clear_first <= 1'h0;
        settle(2);
        rd(`ADDR_WDTCNT, 32'h3, `RESP_OKAY);
        watchdog_clear_second <= 1'h1;
        @(posedge clk);
        watchdog_clear_second <= 1'h0;
        settle(2);
        rd(`ADDR_WDTCNT, 32'h0, `RESP_OKAY);
        wr(`ADDR_OPTION, 32'h5, `RESP_OKAY);
        tick(3);
        rd(`ADDR_WDTCNT, 32'h0, `RESP_OKAY);
        for (t = 0; t < 4; t++) begin
            wr(`ADDR_OPTION, 32'h3 | (t << 4), `RESP_OKAY);
            tick(1 << (12 + t));
            rd(`ADDR_WDTCNT, 32'h0, `RESP_OKAY);
            chk(n_to, t + 1);
        end
        wr(`ADDR_PORTOPT, 32'h0005_A504, `RESP_OKAY);
        n0 = n_wk;
        halted <= 1'h1;
        port_a_in <= 8'hDF;
        settle(8);
        chk(n_wk - n0, 0);
        port_a_in <= 8'hDB;
        settle(8);
        chk(n_wk - n0, 1);
        halted <= 1'h0;
        port_a_in <= 8'hFF;
        settle(8);
        port_a_in <= 8'hFB;
        settle(8);
        chk(n_wk - n0, 1);
        chk({21'h0, port_d_pull, port_c_pull, port_b_pull, port_a_pull}, 32'h5A5);
        wr(`ADDR_OPTION, 32'h3C1, `RESP_OKAY);
        settle(3);
        chk({port_a_bit3, port_d_bit0, pwm_mode_6p2, osc_crystal}, 32'hF);
        wr(`ADDR_OPTION, 32'h1, `RESP_OKAY);
        settle(3);
        chk({port_a_bit3, port_d_bit0, pwm_mode_6p2, osc_crystal}, 32'h0);
        port_a_bit3_level <= 1'h1;
        settle(3);
        chk(32'(port_a_bit3), 32'h1);
        report_and_stop();
    end
endmodule
